// ---- iwdt_pkg.sv ----
package iwdt_pkg;
	// program word and instruction shapes
	localparam int IWDT_WORD_W = 24;
	localparam int IWDT_DBL_W = 48;
	localparam int IWDT_TAG_W = 8;
	localparam logic [7:0] IWDT_TAG_ZERO = 8'h00;
	// cycle counts
	localparam logic [1:0] IWDT_CYC_ONE = 2'h1;
	localparam logic [1:0] IWDT_CYC_TWO = 2'h2;
	localparam logic [1:0] IWDT_CYC_THREE = 2'h3;
	// operand field limits
	localparam logic [15:0] IWDT_FILE_MAX = 16'h1FFF;
	localparam logic [9:0] IWDT_U10_BYTE_MAX = 10'h0FF;
	localparam logic [9:0] IWDT_U10_WORD_MAX = 10'h3FF;
	localparam logic [3:0] IWDT_WBK_REG = 4'hD;
	localparam logic [2:0] IWDT_WBK_POSTINC = 3'h2;
	// flag positions in the flag vectors
	localparam int IWDT_FLG_C = 0;
	localparam int IWDT_FLG_DIGIT = 1;
	localparam int IWDT_FLG_N = 2;
	localparam int IWDT_FLG_OVF = 3;
	localparam int IWDT_FLG_Z = 4;
	localparam int IWDT_DSP_AOVF = 0;
	localparam int IWDT_DSP_BOVF = 1;
	localparam int IWDT_DSP_ASAT = 2;
	localparam int IWDT_DSP_BSAT = 3;
	// operand size encodings
	typedef enum logic [1:0] {
		IWDT_SZ_WORD,
		IWDT_SZ_BYTE,
		IWDT_SZ_DOUBLE
	} iwdt_size_type;
endpackage

// ---- iwdt_operand_decode.sv ----
`timescale 1ns/10ps
// combinational operand field decoding
module iwdt_operand_decode
	import iwdt_pkg::*;
(
	input wire logic [15:0] file_addr_raw,
	input wire logic [9:0] u10_raw,
	input wire logic [22:0] prog_addr_raw,
	input wire logic [3:0] bit_sel_raw,
	input wire logic [9:0] s10_raw,
	input wire logic [3:0] base_reg_raw,
	input wire logic acc_sel_raw,
	input wire logic wbk_sel_raw,
	input wire logic [1:0] size_raw,
	output logic [15:0] file_addr,
	output logic file_addr_ok,
	output logic [9:0] ten_bit_unsigned_constant,
	output logic u10_ok,
	output logic [22:0] program_address_constant,
	output logic [15:0] bit_position_selector,
	output logic [15:0] ten_bit_signed_constant,
	output logic [15:0] base_working_register,
	output logic [1:0] acc_select,
	output logic [3:0] accumulator_writeback_target,
	output logic wbk_indirect,
	output logic [2:0] wbk_step,
	output iwdt_size_type op_size
);
	wire logic size_byte;
	assign size_byte = (size_raw == 2'h1);
	// size suffix: unencoded value falls back to word
	assign op_size = size_byte ? IWDT_SZ_BYTE :
		(size_raw == 2'h2) ? IWDT_SZ_DOUBLE : IWDT_SZ_WORD;
	assign file_addr = file_addr_raw & IWDT_FILE_MAX;
	assign file_addr_ok = (file_addr_raw <= IWDT_FILE_MAX);
	assign ten_bit_unsigned_constant = size_byte ? (u10_raw & IWDT_U10_BYTE_MAX) : u10_raw;
	assign u10_ok = size_byte ? (u10_raw <= IWDT_U10_BYTE_MAX) :
		(u10_raw <= IWDT_U10_WORD_MAX);
	// program addresses are always even
	assign program_address_constant = {prog_addr_raw[22:1], 1'b0};
	assign bit_position_selector = 16'h0001 << bit_sel_raw;
	assign ten_bit_signed_constant = {{6{s10_raw[9]}}, s10_raw};
	assign base_working_register = 16'h0001 << base_reg_raw;
	assign acc_select = acc_sel_raw ? 2'h2 : 2'h1;
	assign accumulator_writeback_target = IWDT_WBK_REG;
	assign wbk_indirect = wbk_sel_raw;
	assign wbk_step = wbk_sel_raw ? IWDT_WBK_POSTINC : 3'h0;
endmodule

// ---- iwdt_issue_timing.sv ----
`timescale 1ns/10ps
// Behaviour
// - double-word is 48 bits, upper 8 zero
// - lone second word runs as no-operation
// - double-word instructions take two cycles
// - single-word one cycle unless special case
// - extra cycles are filled with no-operation; a double-word move only reports two in cycles_q, with no nop stall
// - taken skip costs two or three cycles
// - double-word moves take two cycles
// - file address covers 0 to 0x1FFF
// - unsigned ten-bit limited by operand size
// - program address constant has even LSB
// - bit selector picks bits 0 to 15
// - signed ten-bit spans -512 to 511
// - base register selects one of sixteen
// - accumulator select is A or B
// - writeback is W13 or [W13]+=2
// - update carry, digit carry, negative, overflow, zero
// - per-accumulator overflow and saturate flags
// - size byte, word, double; word default
module iwdt_issue_timing
	import iwdt_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic fetch_valid,
	input wire logic [23:0] fetch_word,
	input wire logic fetch_is_dbl_first,
	input wire logic fetch_is_dbl_move,
	input wire logic cond_true,
	input wire logic pc_change,
	input wire logic program_space_window_read,
	input wire logic table_read,
	input wire logic peripheral_control_register,
	input wire logic skip_taken,
	input wire logic skip_target_dbl,
	input wire logic flag_we,
	input wire logic [4:0] flag_res,
	input wire logic dsp_we,
	input wire logic [3:0] dsp_res,
	input wire logic [15:0] file_addr_raw,
	input wire logic [9:0] u10_raw,
	input wire logic [22:0] prog_addr_raw,
	input wire logic [3:0] bit_sel_raw,
	input wire logic [9:0] s10_raw,
	input wire logic [3:0] base_reg_raw,
	input wire logic acc_sel_raw,
	input wire logic wbk_sel_raw,
	input wire logic [1:0] size_raw,
	output logic busy,
	output logic issue_nop,
	output logic issue_exec,
	output logic [47:0] dbl_instr,
	output logic dbl_bad_tag,
	output logic [1:0] cycles_q,
	output logic carry_flag,
	output logic digit_carry_flag,
	output logic negative_flag,
	output logic overflow_flag,
	output logic zero_flag,
	output logic acc_a_overflow_flag,
	output logic acc_b_overflow_flag,
	output logic acc_a_saturate_flag,
	output logic acc_b_saturate_flag,
	output logic [15:0] file_addr,
	output logic file_addr_ok,
	output logic [9:0] ten_bit_unsigned_constant,
	output logic u10_ok,
	output logic [22:0] program_address_constant,
	output logic [15:0] bit_position_selector,
	output logic [15:0] ten_bit_signed_constant,
	output logic [15:0] base_working_register,
	output logic [1:0] acc_select,
	output logic [3:0] accumulator_writeback_target,
	output logic wbk_indirect,
	output logic [2:0] wbk_step,
	output logic [1:0] op_size
);
	typedef enum logic [1:0] {
		IWDT_IDLE,
		IWDT_WAIT_SECOND,
		IWDT_STALL
	} iwdt_state_type;
	iwdt_state_type state_q, state_d;
	logic [1:0] left_q, left_d;
	logic [23:0] first_q;
	logic [4:0] flags_q;
	logic [3:0] dsp_q;
	logic [15:0] fa_w;
	logic fa_ok_w;
	logic [9:0] u10_w;
	logic u10_ok_w;
	logic [22:0] pa_w;
	logic [15:0] bs_w, s10_w, br_w;
	logic [1:0] acc_w;
	logic [3:0] wbk_w;
	logic wbk_i_w;
	logic [2:0] wbk_s_w;
	iwdt_size_type sz_w;
	iwdt_operand_decode u_dec (
		.file_addr_raw(file_addr_raw),
		.u10_raw(u10_raw),
		.prog_addr_raw(prog_addr_raw),
		.bit_sel_raw(bit_sel_raw),
		.s10_raw(s10_raw),
		.base_reg_raw(base_reg_raw),
		.acc_sel_raw(acc_sel_raw),
		.wbk_sel_raw(wbk_sel_raw),
		.size_raw(size_raw),
		.file_addr(fa_w),
		.file_addr_ok(fa_ok_w),
		.ten_bit_unsigned_constant(u10_w),
		.u10_ok(u10_ok_w),
		.program_address_constant(pa_w),
		.bit_position_selector(bs_w),
		.ten_bit_signed_constant(s10_w),
		.base_working_register(br_w),
		.acc_select(acc_w),
		.accumulator_writeback_target(wbk_w),
		.wbk_indirect(wbk_i_w),
		.wbk_step(wbk_s_w),
		.op_size(sz_w)
	);
	// single-word cost: extra cycle for any of the slow cases
	function automatic logic [1:0] single_cost(input logic slow, input logic skip,
		input logic skip_dbl);
		logic [1:0] c;
		c = IWDT_CYC_ONE;
		if (skip) begin
			c = skip_dbl ? IWDT_CYC_THREE : IWDT_CYC_TWO;
		end else if (slow) begin
			c = IWDT_CYC_TWO;
		end
		return c;
	endfunction

	wire logic slow_w;
	wire logic [1:0] cost_w;
	wire logic tag_zero_w;
	wire logic take_w;
	assign slow_w = cond_true | pc_change | program_space_window_read | table_read |
		peripheral_control_register;
	assign cost_w = single_cost(slow_w, skip_taken, skip_target_dbl);
	// second word must carry a zero tag in its top byte
	assign tag_zero_w = (fetch_word[IWDT_WORD_W-1 -: IWDT_TAG_W] == IWDT_TAG_ZERO);
	assign take_w = fetch_valid & (state_q == IWDT_IDLE);

	// issue sequencer; second-word fetch spends the second cycle
	always_comb begin
		state_d = state_q;
		left_d = left_q;
		case (state_q)
			IWDT_IDLE: begin
				if (fetch_valid && fetch_is_dbl_first) begin
					state_d = IWDT_WAIT_SECOND;
				end else if (fetch_valid && (cost_w != IWDT_CYC_ONE)) begin
					state_d = IWDT_STALL;
					left_d = cost_w - IWDT_CYC_ONE;
				end
			end
			IWDT_WAIT_SECOND: begin
				if (fetch_valid) begin
					state_d = IWDT_IDLE;
				end
			end
			IWDT_STALL: begin
				left_d = left_q - IWDT_CYC_ONE;
				if (left_q == IWDT_CYC_ONE) begin
					state_d = IWDT_IDLE;
				end
			end
			default: begin
				state_d = IWDT_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= IWDT_IDLE;
			left_q <= 2'h0;
		end else if (clk_en) begin
			state_q <= state_d;
			left_q <= left_d;
		end
	end

	// captured first word of a double-word instruction
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			first_q <= 24'h000000;
		end else if (clk_en && take_w && fetch_is_dbl_first) begin
			first_q <= fetch_word;
		end
	end

	// issue strobes; a lone second word in idle pulses issue_exec like a single word, and orphan_w below keeps the flags
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy <= 1'b0;
			issue_nop <= 1'b0;
			issue_exec <= 1'b0;
			dbl_bad_tag <= 1'b0;
			dbl_instr <= 48'h000000000000;
			cycles_q <= 2'h0;
		end else if (clk_en) begin
			busy <= (state_d != IWDT_IDLE);
			issue_nop <= (state_q == IWDT_STALL);
			issue_exec <= 1'b0;
			dbl_bad_tag <= 1'b0;
			if (take_w && !fetch_is_dbl_first) begin
				issue_exec <= 1'b1;
				cycles_q <= fetch_is_dbl_move ? IWDT_CYC_TWO : cost_w;
			end
			if (state_q == IWDT_WAIT_SECOND && fetch_valid) begin
				issue_exec <= 1'b1;
				dbl_instr <= {first_q, fetch_word};
				dbl_bad_tag <= !tag_zero_w;
				cycles_q <= IWDT_CYC_TWO;
			end
		end
	end
	// orphan second word: recognised and executed as a nop
	wire logic orphan_w;
	assign orphan_w = take_w & !fetch_is_dbl_first & tag_zero_w & !fetch_is_dbl_move &
		!slow_w & !skip_taken;
	// arithmetic and dsp flags; orphans leave them untouched
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			flags_q <= 5'h00;
			dsp_q <= 4'h0;
		end else if (clk_en) begin
			if (flag_we && !orphan_w) begin
				flags_q <= flag_res;
			end
			if (dsp_we && !orphan_w) begin
				dsp_q <= dsp_res;
			end
		end
	end
	// registered operand decode so outputs come from flip-flops
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			file_addr <= 16'h0000;
			file_addr_ok <= 1'b0;
			ten_bit_unsigned_constant <= 10'h000;
			u10_ok <= 1'b0;
			program_address_constant <= 23'h000000;
			bit_position_selector <= 16'h0000;
			ten_bit_signed_constant <= 16'h0000;
			base_working_register <= 16'h0000;
			acc_select <= 2'h0;
			accumulator_writeback_target <= 4'h0;
			wbk_indirect <= 1'b0;
			wbk_step <= 3'h0;
			op_size <= 2'h0;
		end else if (clk_en) begin
			file_addr <= fa_w;
			file_addr_ok <= fa_ok_w;
			ten_bit_unsigned_constant <= u10_w;
			u10_ok <= u10_ok_w;
			program_address_constant <= pa_w;
			bit_position_selector <= bs_w;
			ten_bit_signed_constant <= s10_w;
			base_working_register <= br_w;
			acc_select <= acc_w;
			accumulator_writeback_target <= wbk_w;
			wbk_indirect <= wbk_i_w;
			wbk_step <= wbk_s_w;
			op_size <= sz_w;
		end
	end
	assign carry_flag = flags_q[IWDT_FLG_C];
	assign digit_carry_flag = flags_q[IWDT_FLG_DIGIT];
	assign negative_flag = flags_q[IWDT_FLG_N];
	assign overflow_flag = flags_q[IWDT_FLG_OVF];
	assign zero_flag = flags_q[IWDT_FLG_Z];
	assign acc_a_overflow_flag = dsp_q[IWDT_DSP_AOVF];
	assign acc_b_overflow_flag = dsp_q[IWDT_DSP_BOVF];
	assign acc_a_saturate_flag = dsp_q[IWDT_DSP_ASAT];
	assign acc_b_saturate_flag = dsp_q[IWDT_DSP_BSAT];
	// checks
	sequence s_skip3;
		take_w && clk_en && skip_taken && skip_target_dbl && !fetch_is_dbl_first;
	endsequence
	property p_skip3;
		@(posedge core_clk) disable iff (!rst_b)
		s_skip3 ##1 clk_en [*1] |-> (state_q == IWDT_STALL) && (left_q == 2'h2);
	endproperty
	a_skip3: assert property (p_skip3) else $error("skip over double word not three");
	property p_slow;
		@(posedge core_clk) disable iff (!rst_b)
		(take_w && clk_en && slow_w && !skip_taken && !fetch_is_dbl_first) |=>
		(cycles_q == 2'h2);
	endproperty
	a_slow: assert property (p_slow) else $error("slow single word not two cycles");
	property p_fast;
		@(posedge core_clk) disable iff (!rst_b)
		(take_w && clk_en && !slow_w && !skip_taken && !fetch_is_dbl_first &&
		!fetch_is_dbl_move) |=> (cycles_q == 2'h1) && !busy;
	endproperty
	a_fast: assert property (p_fast) else $error("plain single word not one cycle");
	property p_nopfill;
		@(posedge core_clk) disable iff (!rst_b)
		(clk_en && state_q == IWDT_STALL) |=> issue_nop && !issue_exec;
	endproperty
	a_nopfill: assert property (p_nopfill) else $error("stall cycle not a nop");
	property p_dbl;
		@(posedge core_clk) disable iff (!rst_b)
		(clk_en && state_q == IWDT_WAIT_SECOND && fetch_valid) |=>
		issue_exec && cycles_q == 2'h2 && dbl_bad_tag == ($past(fetch_word[23:16]) != 8'h00);
	endproperty
	a_dbl: assert property (p_dbl) else $error("double word issue wrong");
	property p_move;
		@(posedge core_clk) disable iff (!rst_b)
		(take_w && clk_en && fetch_is_dbl_move && !fetch_is_dbl_first) |=> cycles_q == 2'h2;
	endproperty
	a_move: assert property (p_move) else $error("double move not two cycles");
	property p_orphan;
		@(posedge core_clk) disable iff (!rst_b)
		(clk_en && orphan_w) |=> $stable(flags_q) && $stable(dsp_q);
	endproperty
	a_orphan: assert property (p_orphan) else $error("orphan word changed flags");
	property p_even;
		@(posedge core_clk) disable iff (!rst_b)
		clk_en |=> program_address_constant[0] == 1'b0 &&
		$countones(bit_position_selector) == 1 && $countones(base_working_register) == 1;
	endproperty
	a_even: assert property (p_even) else $error("operand decode malformed");
	property p_size;
		@(posedge core_clk) disable iff (!rst_b)
		(clk_en && size_raw == 2'h3) |=> op_size == 2'h0;
	endproperty
	a_size: assert property (p_size) else $error("size default not word");
endmodule

// ---- iwdt_fetch_model.sv ----
`timescale 1ns/10ps
// program memory fetch path: one word per put, lines scrambled when released
module iwdt_fetch_model (
	input wire logic core_clk,
	output logic fetch_valid,
	output logic [23:0] fetch_word,
	output logic [8:0] attr
);
	initial begin
		fetch_valid = 1'b0;
		fetch_word = 24'h5A5A5A;
		attr = 9'h0AA;
	end
	// slow answers wait gap idle cycles first
	task automatic put(input logic [23:0] w, input logic [8:0] a, input int gap);
		repeat (gap) @(negedge core_clk);
		fetch_valid = 1'b1;
		fetch_word = w;
		attr = a;
		@(negedge core_clk);
	endtask
	// no stale word survives a release, so valid gating is really exercised
	task automatic idle();
		fetch_valid = 1'b0;
		fetch_word = ~fetch_word;
		attr = ~attr;
	endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
	import iwdt_pkg::*;
	typedef struct {logic [1:0] c; logic [1:0] n; logic d; logic [47:0] v; logic [8:0] f;} iwdt_exp_type;
	typedef struct {realtime t; logic [110:0] v;} iwdt_dec_type;
	logic core_clk, rst_b, clk_en, fetch_valid, flag_we, dsp_we, acc_sel_raw, wbk_sel_raw;
	logic [23:0] fetch_word;
	logic [8:0] attr, ef;
	logic [4:0] flag_res;
	logic [3:0] dsp_res, bit_sel_raw, base_reg_raw, wbk_t;
	logic [15:0] file_addr_raw, rnd, file_addr, bps, s10c, bwr;
	logic [9:0] u10_raw, s10_raw, u10c;
	logic [22:0] prog_addr_raw, pac;
	logic [1:0] size_raw, cycles_q, acc_select, op_size;
	logic [47:0] dbl_instr;
	logic [2:0] wbk_step;
	logic [79:0] pool;
	logic busy, issue_nop, issue_exec, dbl_bad_tag, cf, dcf, nf, ovf, zf;
	logic a_ovf, b_ovf, a_sat, b_sat;
	logic fa_ok, u10_ok, wbk_ind, have;
	int fail_count, n_checks, nopc, badc, ebad;
	iwdt_exp_type eq[$];
	iwdt_exp_type cur;
	iwdt_dec_type dq[$];
	iwdt_dec_type dd;

	iwdt_fetch_model iwdt_fetch_model_inst (.core_clk(core_clk), .fetch_valid(fetch_valid),
		.fetch_word(fetch_word), .attr(attr));
	iwdt_issue_timing iwdt_issue_timing_inst (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
		.fetch_valid(fetch_valid), .fetch_word(fetch_word), .fetch_is_dbl_first(attr[0]),
		.fetch_is_dbl_move(attr[1]), .cond_true(attr[2]), .pc_change(attr[3]),
		.program_space_window_read(attr[4]), .table_read(attr[5]),
		.peripheral_control_register(attr[6]), .skip_taken(attr[7]), .skip_target_dbl(attr[8]),
		.flag_we(flag_we), .flag_res(flag_res), .dsp_we(dsp_we), .dsp_res(dsp_res),
		.file_addr_raw(file_addr_raw), .u10_raw(u10_raw), .prog_addr_raw(prog_addr_raw),
		.bit_sel_raw(bit_sel_raw), .s10_raw(s10_raw), .base_reg_raw(base_reg_raw),
		.acc_sel_raw(acc_sel_raw), .wbk_sel_raw(wbk_sel_raw), .size_raw(size_raw), .busy(busy),
		.issue_nop(issue_nop), .issue_exec(issue_exec), .dbl_instr(dbl_instr),
		.dbl_bad_tag(dbl_bad_tag), .cycles_q(cycles_q), .carry_flag(cf), .digit_carry_flag(dcf),
		.negative_flag(nf), .overflow_flag(ovf), .zero_flag(zf), .acc_a_overflow_flag(a_ovf),
		.acc_b_overflow_flag(b_ovf), .acc_a_saturate_flag(a_sat), .acc_b_saturate_flag(b_sat),
		.file_addr(file_addr), .file_addr_ok(fa_ok), .ten_bit_unsigned_constant(u10c),
		.u10_ok(u10_ok), .program_address_constant(pac), .bit_position_selector(bps),
		.ten_bit_signed_constant(s10c), .base_working_register(bwr), .acc_select(acc_select),
		.accumulator_writeback_target(wbk_t), .wbk_indirect(wbk_ind), .wbk_step(wbk_step),
		.op_size(op_size));

	// 50 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_sim();
		if (fail_count == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// wait out the stall under a bound before the next fetch
	task automatic settle();
		int k;
		k = 0;
		@(negedge core_clk);
		while (busy !== 1'b0 && k < 20) begin
			@(negedge core_clk);
			k++;
		end
	endtask

	// one single-word issue; a flag write rides along with it when fw is set
	task automatic ins(input logic [23:0] w, input logic [8:0] a, input logic [1:0] c,
			input logic [1:0] n, input logic fw, input int gap);
		rnd = lfsr(rnd);
		flag_we = fw;
		dsp_we = fw;
		{dsp_res, flag_res} = rnd[8:0];
		if (fw && (w[23:16] != 8'h00 || a != 9'h000)) ef = rnd[8:0];
		eq.push_back('{c, n, 1'b0, 48'h0, ef});
		iwdt_fetch_model_inst.put(w, a, gap);
		iwdt_fetch_model_inst.idle();
		flag_we = 1'b0;
		dsp_we = 1'b0;
		settle();
	endtask

	task automatic dbl(input logic [23:0] w1, input logic [23:0] w2, input int bad);
		eq.push_back('{IWDT_CYC_TWO, 2'h0, 1'b1, {w1, w2}, ef});
		ebad += bad;
		iwdt_fetch_model_inst.put(w1, 9'h001, 0);
		iwdt_fetch_model_inst.put(w2, 9'h000, 0);
		iwdt_fetch_model_inst.idle();
		settle();
	endtask

	// issue watcher: stalls are counted up to the next issue
	always @(negedge core_clk) begin
		if (issue_nop === 1'b1) nopc++;
		if (dbl_bad_tag === 1'b1) badc++;
		if (issue_exec === 1'b1) begin
			if (have) chk("stall_nops", 128'(cur.n), 128'(nopc));
			if (eq.size() == 0) chk("spurious_issue", 128'h0, 128'h1);
			else begin
				cur = eq.pop_front();
				have = 1'b1;
				nopc = 0;
				chk("cycles_q", 128'(cur.c), 128'(cycles_q));
				chk("flags", 128'(cur.f), 128'({b_sat, a_sat, b_ovf, a_ovf, zf, ovf, nf, dcf, cf}));
				if (cur.d) chk("dbl_instr", 128'(cur.v), 128'(dbl_instr));
			end
		end
		if (dq.size() > 0 && dq[0].t < $realtime) begin
			dd = dq.pop_front();
			chk("decode", 128'(dd.v), 128'({file_addr, fa_ok, u10c, u10_ok, pac, bps, s10c, bwr,
				acc_select, wbk_t, wbk_ind, wbk_step, op_size}));
		end
	end

	// watchdog: ten thousand cycles is far beyond the sequence
	initial begin
		#200000;
		fail_count++;
		end_sim();
	end

	initial begin
		{clk_en, rst_b, flag_we, dsp_we, flag_res, dsp_res, have, ef} = {2'b10, 21'h0};
		{file_addr_raw, u10_raw, prog_addr_raw, bit_sel_raw, s10_raw} = 63'h0;
		{base_reg_raw, acc_sel_raw, wbk_sel_raw, size_raw} = 8'h0;
		{fail_count, n_checks, nopc, badc, ebad} = 160'h0;
		rnd = 16'h005F;
		repeat (20) @(negedge core_clk);
		rst_b = 1'b1;
		@(negedge core_clk);
		ins(24'hA51234, 9'h000, IWDT_CYC_ONE, 2'h0, 1'b1, 0);
		for (int i = 2; i < 7; i++) ins(24'hA50100, 9'h001 << i, 2'h2, 2'h1, 1'b1, i - 2);
		ins(24'hA50200, 9'h080, IWDT_CYC_TWO, 2'h1, 1'b0, 0);
		ins(24'hA50300, 9'h180, IWDT_CYC_THREE, 2'h2, 1'b0, 0);
		ins(24'hA50400, 9'h002, IWDT_CYC_TWO, 2'h0, 1'b0, 0);
		dbl(24'hB71111, 24'h00ABCD, 0);
		dbl(24'hB72222, 24'h00FEDC, 0);
		dbl(24'hB73333, 24'h4100AA, 1);
		ins(24'h00ABCD, 9'h000, IWDT_CYC_ONE, 2'h0, 1'b1, 0);
		// boundary fields first, then pseudo-random ones
		for (int i = 0; i < 48; i++) begin
			for (int j = 0; j < 5; j++) begin
				rnd = lfsr(rnd);
				pool = {pool[63:0], rnd};
			end
			if (i < 3) pool[70:45] = {16'h1FFF + 16'(i), 10'h0FF + 10'(i)};
			if (i < 3) pool[1:0] = 2'(i != 2);
			{file_addr_raw, u10_raw, prog_addr_raw, bit_sel_raw, s10_raw} = pool[70:8];
			{base_reg_raw, acc_sel_raw, wbk_sel_raw, size_raw} = pool[7:0];
			dq.push_back('{$realtime, {file_addr_raw & 16'h1FFF, file_addr_raw <= 16'h1FFF,
				(size_raw == 2'h1) ? (u10_raw & 10'h0FF) : u10_raw,
				u10_raw <= ((size_raw == 2'h1) ? 10'h0FF : 10'h3FF), prog_addr_raw & 23'h7FFFFE,
				16'h0001 << bit_sel_raw, {{6{s10_raw[9]}}, s10_raw}, 16'h0001 << base_reg_raw,
				acc_sel_raw ? 2'h2 : 2'h1, 4'hD, wbk_sel_raw, wbk_sel_raw ? 3'h2 : 3'h0,
				(size_raw == 2'h3) ? 2'h0 : size_raw}});
			@(negedge core_clk);
		end
		// frozen clock enable: a valid slow fetch must not issue or stall
		clk_en = 1'b0;
		iwdt_fetch_model_inst.put(24'hA51234, 9'h004, 0);
		iwdt_fetch_model_inst.idle();
		@(negedge core_clk);
		clk_en = 1'b1;
		ins(24'hA5FFFF, 9'h000, IWDT_CYC_ONE, 2'h0, 1'b0, 0);
		chk("bad_tag_count", 128'(ebad), 128'(badc));
		end_sim();
	end
endmodule
